// [ultrasonic_burst_pulse_generator.sv]
// Two-channel burst pulse generator for low-side transducer switch gates
//
// Notes on behaviour
// - Mode 000: push-pull pair, channel A timing, dead gap
// - Mode 010: A from port bit0, B generator
// - Mode 011: both outputs from their own generators
// - Mode 100: both outputs from processor port bits
// - Writing start bit one launches that channel's burst if its generator drives an output in the current mode, is idle and has a nonzero pulse count
// - Burst emits programmed pulse count, 0 to 63
// - On and off phases timed by 11-bit counts
// - Port modes: A mirrors bit0, B mirrors bit1
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ultrasonic_burst_pulse_generator (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_port2_bit0,
    input wire logic cpu_port2_bit1,
    output logic gate_output_a,
    output logic gate_output_b
);

    burst_pkg::burst_mode_e mode;
    burst_pkg::gen_cfg_s cfg [burst_pkg::NUM_CH];
    logic [burst_pkg::GAP_W-1:0] gap_interval_count;
    burst_pkg::gen_state_e state [burst_pkg::NUM_CH];
    logic [burst_pkg::TIME_W-1:0] timer [burst_pkg::NUM_CH];
    logic [burst_pkg::PULSE_W-1:0] left [burst_pkg::NUM_CH];
    logic [burst_pkg::NUM_CH-1:0] pp_run;
    logic [burst_pkg::NUM_CH-1:0] gen_on;
    logic [burst_pkg::NUM_CH-1:0] gen_alt;
    logic [burst_pkg::NUM_CH-1:0] busy;
    logic [burst_pkg::NUM_CH-1:0] gen_drive;
    logic [burst_pkg::NUM_CH-1:0] start_ok;
    logic loaded;
    logic addr_hit;
    logic wr_fire;
    logic [31:0] rd_val;

    // Last tick of a phase; a zero count still lasts one cycle
    function automatic logic [burst_pkg::TIME_W-1:0] last_tick(
        input logic [burst_pkg::TIME_W-1:0] len
    );
        return (len == '0) ? '0 : len - 11'h001;
    endfunction : last_tick

    // Address decode and read mux
    always_comb begin
        addr_hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            burst_pkg::OFS_MODE: rd_val[2:0] = mode;
            burst_pkg::OFS_START: rd_val[1:0] = busy;
            burst_pkg::OFS_CFG_A: begin
                rd_val[burst_pkg::CFG_PULSE_LSB +: burst_pkg::PULSE_W] = cfg[0].pulses;
                rd_val[burst_pkg::CFG_ON_LSB +: burst_pkg::TIME_W] = cfg[0].on_len;
                rd_val[burst_pkg::CFG_OFF_LSB +: burst_pkg::TIME_W] = cfg[0].off_len;
            end
            burst_pkg::OFS_CFG_B: begin
                rd_val[burst_pkg::CFG_PULSE_LSB +: burst_pkg::PULSE_W] = cfg[1].pulses;
                rd_val[burst_pkg::CFG_ON_LSB +: burst_pkg::TIME_W] = cfg[1].on_len;
                rd_val[burst_pkg::CFG_OFF_LSB +: burst_pkg::TIME_W] = cfg[1].off_len;
            end
            burst_pkg::OFS_GAP: rd_val[burst_pkg::GAP_W-1:0] = gap_interval_count;
            burst_pkg::OFS_STATUS: begin
                rd_val[burst_pkg::ST_BUSY_LSB +: 2] = busy;
                rd_val[burst_pkg::ST_OUT_LSB +: 2] = {gate_output_b, gate_output_a};
                rd_val[burst_pkg::ST_LEFT_A_LSB +: burst_pkg::PULSE_W] = left[0];
                rd_val[burst_pkg::ST_LEFT_B_LSB +: burst_pkg::PULSE_W] = left[1];
            end
            default: addr_hit = 1'b0;
        endcase
    end

    // Read data is captured one cycle ahead, so the access needs no wait state while clk_en is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            loaded <= 1'b0;
        end else if (clk_en) begin
            if (psel && !(penable && loaded)) begin
                prdata <= rd_val;
                loaded <= 1'b1;
            end else begin
                loaded <= 1'b0;
            end
        end
    end

    // A frozen clock enable also holds off bus completion
    assign pready = clk_en && loaded;
    assign pslverr = pready && !addr_hit;
    assign wr_fire = psel && penable && pwrite && pready && addr_hit;

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= burst_pkg::MODE_RESET;
            cfg[0] <= burst_pkg::CFG_RESET;
            cfg[1] <= burst_pkg::CFG_RESET;
            gap_interval_count <= burst_pkg::GAP_RESET;
        end else if (wr_fire) begin
            case (paddr)
                burst_pkg::OFS_MODE: mode <= burst_pkg::burst_mode_e'(pwdata[2:0]);
                burst_pkg::OFS_CFG_A: cfg[0] <= '{
                    pulses: pwdata[burst_pkg::CFG_PULSE_LSB +: burst_pkg::PULSE_W],
                    on_len: pwdata[burst_pkg::CFG_ON_LSB +: burst_pkg::TIME_W],
                    off_len: pwdata[burst_pkg::CFG_OFF_LSB +: burst_pkg::TIME_W]};
                burst_pkg::OFS_CFG_B: cfg[1] <= '{
                    pulses: pwdata[burst_pkg::CFG_PULSE_LSB +: burst_pkg::PULSE_W],
                    on_len: pwdata[burst_pkg::CFG_ON_LSB +: burst_pkg::TIME_W],
                    off_len: pwdata[burst_pkg::CFG_OFF_LSB +: burst_pkg::TIME_W]};
                burst_pkg::OFS_GAP: gap_interval_count <= pwdata[burst_pkg::GAP_W-1:0];
                default: ;
            endcase
        end
    end

    // Which generators own an output in the current mode
    assign gen_drive[0] = (mode == burst_pkg::MODE_PUSH_PULL)
        || (mode == burst_pkg::MODE_GEN_A_CPU_B) || (mode == burst_pkg::MODE_GEN_BOTH);
    assign gen_drive[1] = (mode == burst_pkg::MODE_CPU_A_GEN_B)
        || (mode == burst_pkg::MODE_GEN_BOTH);

    // Start strobes; a start to a port-driven channel is dropped
    assign start_ok = (wr_fire && paddr == burst_pkg::OFS_START)
        ? (pwdata[1:0] & gen_drive) : 2'b00;

    // Per-channel burst sequencer
    generate
        for (genvar ch = 0; ch < burst_pkg::NUM_CH; ch++) begin : g_gen
            logic [burst_pkg::TIME_W-1:0] gap_len;
            logic [burst_pkg::TIME_W-1:0] on_run;
            logic [burst_pkg::PULSE_W-1:0] emitted;
            logic [burst_pkg::PULSE_W-1:0] goal;

            assign gap_len = {3'b000, gap_interval_count};
            assign gen_on[ch] = (state[ch] == burst_pkg::GEN_ON);
            assign gen_alt[ch] = (state[ch] == burst_pkg::GEN_OFF) && pp_run[ch];
            assign busy[ch] = (state[ch] != burst_pkg::GEN_IDLE);

            // Phase walk: on, optional gap, off, optional gap, next pulse
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    state[ch] <= burst_pkg::GEN_IDLE;
                    timer[ch] <= burst_pkg::TIMER_RESET;
                    left[ch] <= burst_pkg::LEFT_RESET;
                    pp_run[ch] <= 1'b0;
                end else if (clk_en) begin
                    case (state[ch])
                        burst_pkg::GEN_IDLE: begin
                            if (start_ok[ch] && cfg[ch].pulses != '0) begin
                                state[ch] <= burst_pkg::GEN_ON;
                                timer[ch] <= last_tick(cfg[ch].on_len);
                                left[ch] <= cfg[ch].pulses;
                                pp_run[ch] <= (ch == 0) && (mode == burst_pkg::MODE_PUSH_PULL);
                            end
                        end
                        burst_pkg::GEN_ON: begin
                            if (timer[ch] != '0) begin
                                timer[ch] <= timer[ch] - 11'h001;
                            end else if (pp_run[ch]) begin
                                state[ch] <= burst_pkg::GEN_GAP1;
                                timer[ch] <= last_tick(gap_len);
                            end else begin
                                state[ch] <= burst_pkg::GEN_OFF;
                                timer[ch] <= last_tick(cfg[ch].off_len);
                            end
                        end
                        burst_pkg::GEN_GAP1: begin
                            if (timer[ch] != '0) begin
                                timer[ch] <= timer[ch] - 11'h001;
                            end else begin
                                state[ch] <= burst_pkg::GEN_OFF;
                                timer[ch] <= last_tick(cfg[ch].off_len);
                            end
                        end
                        burst_pkg::GEN_OFF: begin
                            if (timer[ch] != '0) begin
                                timer[ch] <= timer[ch] - 11'h001;
                            end else if (left[ch] == 6'h01) begin
                                state[ch] <= burst_pkg::GEN_IDLE;
                                left[ch] <= burst_pkg::LEFT_RESET;
                                pp_run[ch] <= 1'b0;
                            end else begin
                                left[ch] <= left[ch] - 6'h01;
                                state[ch] <= pp_run[ch] ? burst_pkg::GEN_GAP2 : burst_pkg::GEN_ON;
                                timer[ch] <= pp_run[ch] ? last_tick(gap_len)
                                                        : last_tick(cfg[ch].on_len);
                            end
                        end
                        burst_pkg::GEN_GAP2: begin
                            if (timer[ch] != '0) begin
                                timer[ch] <= timer[ch] - 11'h001;
                            end else begin
                                state[ch] <= burst_pkg::GEN_ON;
                                timer[ch] <= last_tick(cfg[ch].on_len);
                            end
                        end
                        default: state[ch] <= burst_pkg::GEN_IDLE;
                    endcase
                end
            end

            // Checker-only counters: on-phase length and pulses per burst
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    on_run <= 11'h000;
                    emitted <= 6'h00;
                    goal <= 6'h00;
                end else if (clk_en) begin
                    on_run <= gen_on[ch] && timer[ch] != '0 ? on_run + 11'h001 : 11'h000;
                    if (state[ch] == burst_pkg::GEN_IDLE) begin
                        emitted <= 6'h00;
                        goal <= cfg[ch].pulses;
                    end else if (gen_on[ch] && timer[ch] == '0) begin
                        emitted <= emitted + 6'h01;
                    end
                end
            end

            chk_start_launch: assert property (@(posedge pclk) disable iff (!presetn)
                (clk_en && start_ok[ch] && !busy[ch] && cfg[ch].pulses != '0)
                |=> gen_on[ch] && left[ch] == $past(cfg[ch].pulses))
                else $error("start bit did not launch a burst");

            chk_on_length: assert property (@(posedge pclk) disable iff (!presetn)
                (clk_en && gen_on[ch] && timer[ch] == '0)
                |-> on_run == last_tick(cfg[ch].on_len))
                else $error("on phase length differs from on count");

            chk_pulse_total: assert property (@(posedge pclk) disable iff (!presetn)
                (clk_en && state[ch] == burst_pkg::GEN_OFF && timer[ch] == '0
                 && left[ch] == 6'h01) |-> emitted == goal)
                else $error("burst pulse count differs from programmed total");

            chk_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
                (state[ch] == burst_pkg::GEN_IDLE && !(clk_en && start_ok[ch]))
                |=> state[ch] == burst_pkg::GEN_IDLE && !gen_on[ch] && !gen_alt[ch])
                else $error("idle generator moved without a start");
        end
    endgenerate

    // Output routing per mode; reserved codes keep both switches off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_output_a <= 1'b0;
            gate_output_b <= 1'b0;
        end else if (clk_en) begin
            case (mode)
                burst_pkg::MODE_PUSH_PULL: begin
                    gate_output_a <= gen_on[0];
                    gate_output_b <= gen_alt[0];
                end
                burst_pkg::MODE_GEN_A_CPU_B: begin
                    gate_output_a <= gen_on[0];
                    gate_output_b <= cpu_port2_bit1;
                end
                burst_pkg::MODE_CPU_A_GEN_B: begin
                    gate_output_a <= cpu_port2_bit0;
                    gate_output_b <= gen_on[1];
                end
                burst_pkg::MODE_GEN_BOTH: begin
                    gate_output_a <= gen_on[0];
                    gate_output_b <= gen_on[1];
                end
                burst_pkg::MODE_CPU_BOTH: begin
                    gate_output_a <= cpu_port2_bit0;
                    gate_output_b <= cpu_port2_bit1;
                end
                default: begin
                    gate_output_a <= 1'b0;
                    gate_output_b <= 1'b0;
                end
            endcase
        end
    end

    // Push-pull must never close both switches: dead gap keeps them apart
    chk_pushpull_excl: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && mode == burst_pkg::MODE_PUSH_PULL) |=> !(gate_output_a && gate_output_b))
        else $error("push-pull outputs both on");

    chk_port_a_mirror: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && mode == burst_pkg::MODE_CPU_A_GEN_B)
        |=> gate_output_a == $past(cpu_port2_bit0) && gate_output_b == $past(gen_on[1]))
        else $error("mode 010 routing wrong");

    chk_both_gens: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && mode == burst_pkg::MODE_GEN_BOTH)
        |=> gate_output_a == $past(gen_on[0]) && gate_output_b == $past(gen_on[1]))
        else $error("mode 011 routing wrong");

    chk_port_mirror: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && mode == burst_pkg::MODE_CPU_BOTH)
        |=> gate_output_a == $past(cpu_port2_bit0) && gate_output_b == $past(cpu_port2_bit1))
        else $error("port-driven outputs do not mirror port bits");

    chk_reserved_off: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && mode[2] && mode[1:0] != 2'b00) |=> !gate_output_a && !gate_output_b)
        else $error("reserved mode drives an output");

    // Push-pull: every A on phase closes into a dead gap before B turns on
    sequence s_pp_on_end;
        clk_en && pp_run[0] && gen_on[0] && timer[0] == '0;
    endsequence

    chk_dead_gap: assert property (@(posedge pclk) disable iff (!presetn)
        s_pp_on_end |=> state[0] == burst_pkg::GEN_GAP1)
        else $error("push-pull on phase skipped the dead gap");

endmodule : ultrasonic_burst_pulse_generator
`default_nettype wire

// [burst_pkg.sv]
// Constants, register map and types shared by the burst pulse generator
package burst_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_START = 8'h04;
    localparam logic [7:0] OFS_CFG_A = 8'h08;
    localparam logic [7:0] OFS_CFG_B = 8'h0c;
    localparam logic [7:0] OFS_GAP = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // Field widths
    localparam int PULSE_W = 6;
    localparam int TIME_W = 11;
    localparam int GAP_W = 8;
    localparam int NUM_CH = 2;

    // Field positions inside the generator configuration word
    localparam int CFG_PULSE_LSB = 0;
    localparam int CFG_ON_LSB = 8;
    localparam int CFG_OFF_LSB = 20;

    // Field positions inside the status word
    localparam int ST_BUSY_LSB = 0;
    localparam int ST_OUT_LSB = 2;
    localparam int ST_LEFT_A_LSB = 8;
    localparam int ST_LEFT_B_LSB = 16;

    // Drive mode codes
    typedef enum logic [2:0] {
        MODE_PUSH_PULL = 3'b000,
        MODE_GEN_A_CPU_B = 3'b001,
        MODE_CPU_A_GEN_B = 3'b010,
        MODE_GEN_BOTH = 3'b011,
        MODE_CPU_BOTH = 3'b100,
        MODE_RSVD_5 = 3'b101,
        MODE_RSVD_6 = 3'b110,
        MODE_RSVD_7 = 3'b111
    } burst_mode_e;

    // Per-pulse phase sequencer states
    typedef enum logic [2:0] {
        GEN_IDLE = 3'b000,
        GEN_ON = 3'b001,
        GEN_GAP1 = 3'b010,
        GEN_OFF = 3'b011,
        GEN_GAP2 = 3'b100
    } gen_state_e;

    // One generator's burst settings
    typedef struct packed {
        logic [PULSE_W-1:0] pulses;
        logic [TIME_W-1:0] on_len;
        logic [TIME_W-1:0] off_len;
    } gen_cfg_s;

    // Values after reset
    localparam burst_mode_e MODE_RESET = MODE_PUSH_PULL;
    localparam gen_cfg_s CFG_RESET = '0;
    localparam logic [GAP_W-1:0] GAP_RESET = 8'h00;
    localparam logic [TIME_W-1:0] TIMER_RESET = 11'h000;
    localparam logic [PULSE_W-1:0] LEFT_RESET = 6'h00;

endpackage : burst_pkg

// [burst_load_model.sv]
// Behavioural load: low-side switch pair seen through the transformer
`timescale 1ns/1ps
`default_nettype none

module burst_load_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic gate_a,
    input wire logic gate_b,
    output logic [7:0] pulses_a,
    output logic [7:0] pulses_b,
    output logic shoot_through
);
    logic last_a;
    logic last_b;

    // Each switch turn-on is one primary current pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn || clear) begin
            last_a <= 1'b0;
            last_b <= 1'b0;
            pulses_a <= 8'h00;
            pulses_b <= 8'h00;
        end else begin
            last_a <= gate_a;
            last_b <= gate_b;
            pulses_a <= pulses_a + 8'(gate_a & ~last_a);
            pulses_b <= pulses_b + 8'(gate_b & ~last_b);
        end
    end

    // Both switches on shorts the push-pull primaries; sticky so no pulse is missed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn || clear) begin
            shoot_through <= 1'b0;
        end else if (gate_a && gate_b) begin
            shoot_through <= 1'b1;
        end
    end
endmodule : burst_load_model
`default_nettype wire

// [tb_ultrasonic_burst_pulse_generator.sv]
// Self-checking bench for the burst pulse generator
`timescale 1ns/1ps
`default_nettype none

module tb_ultrasonic_burst_pulse_generator;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpu_port2_bit0 = 1'b0;
    logic cpu_port2_bit1 = 1'b0;
    logic gate_output_a;
    logic gate_output_b;
    logic clear = 1'b0;
    logic [7:0] pulses_a;
    logic [7:0] pulses_b;
    logic shoot_through;
    int failures = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic er;

    always #5 pclk = ~pclk;

    ultrasonic_burst_pulse_generator i_ultrasonic_burst_pulse_generator (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_port2_bit0(cpu_port2_bit0), .cpu_port2_bit1(cpu_port2_bit1),
        .gate_output_a(gate_output_a), .gate_output_b(gate_output_b));

    burst_load_model u_load (
        .pclk(pclk), .presetn(presetn), .clear(clear), .gate_a(gate_output_a),
        .gate_b(gate_output_b), .pulses_a(pulses_a), .pulses_b(pulses_b),
        .shoot_through(shoot_through));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // One APB transfer; returns just after the completing edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Sample pready, data and error at the completing rising edge only
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] cfg(input int p, input int on, input int off);
        return 32'(p) | (32'(on) << burst_pkg::CFG_ON_LSB) | (32'(off) << burst_pkg::CFG_OFF_LSB);
    endfunction : cfg

    task automatic wait_clear(input int n);
        repeat (n) @(posedge pclk);
        clear <= 1'b1;
        @(posedge pclk);
        clear <= 1'b0;
        #1;
    endtask : wait_clear

    task automatic test_reset_map;
        apb(1'b0, burst_pkg::OFS_MODE, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, burst_pkg::OFS_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, er}, 32'h1);
        $display("test reset_map done");
    endtask : test_reset_map

    // Two pulses, on 2 off 1, checked cycle by cycle after the start edge
    task automatic test_gen_both;
        logic [8:0] mask;
        mask = 9'h036;
        apb(1'b1, burst_pkg::OFS_MODE, 32'h3);
        apb(1'b1, burst_pkg::OFS_CFG_A, cfg(2, 2, 1));
        apb(1'b1, burst_pkg::OFS_START, 32'h1);
        for (int k = 1; k <= 8; k++) begin
            @(posedge pclk);
            #1;
            check({31'h0, gate_output_a}, {31'h0, mask[k]});
            check({31'h0, gate_output_b}, 32'h0);
        end
        wait_clear(10);
        check({24'h0, pulses_a}, 32'h0);
        apb(1'b1, burst_pkg::OFS_CFG_B, cfg(63, 0, 0));
        apb(1'b1, burst_pkg::OFS_START, 32'h2);
        repeat (300) @(posedge pclk);
        check({24'h0, pulses_b}, 32'd63);
        apb(1'b0, burst_pkg::OFS_START, 32'h0);
        check(rd & 32'h3, 32'h0);
        $display("test gen_both done");
    endtask : test_gen_both

    // A follows port bit 0 while generator B runs three pulses
    task automatic test_cpu_a_gen_b;
        wait_clear(2);
        apb(1'b1, burst_pkg::OFS_MODE, 32'h2);
        apb(1'b1, burst_pkg::OFS_CFG_B, cfg(3, 3, 2));
        apb(1'b1, burst_pkg::OFS_START, 32'h3);
        apb(1'b0, burst_pkg::OFS_START, 32'h0);
        check(rd & 32'h3, 32'h2);
        for (int k = 0; k < 8; k++) begin
            @(posedge pclk);
            cpu_port2_bit0 <= k[1];
            @(posedge pclk);
            #1;
            check({31'h0, gate_output_a}, {31'h0, cpu_port2_bit0});
        end
        repeat (30) @(posedge pclk);
        #1;
        check({24'h0, pulses_b}, 32'd3);
        wait_clear(10);
        check({24'h0, pulses_b}, 32'd0);
        cpu_port2_bit0 <= 1'b0;
        $display("test cpu_a_gen_b done");
    endtask : test_cpu_a_gen_b

    // Both outputs mirror the port; a start request must change nothing
    task automatic test_cpu_both;
        apb(1'b1, burst_pkg::OFS_MODE, 32'h4);
        apb(1'b1, burst_pkg::OFS_CFG_A, cfg(5, 1, 1));
        apb(1'b1, burst_pkg::OFS_START, 32'h3);
        for (int k = 0; k < 8; k++) begin
            cpu_port2_bit0 <= k[0];
            cpu_port2_bit1 <= k[1];
            @(posedge pclk);
            @(posedge pclk);
            #1;
            check({30'h0, gate_output_b, gate_output_a}, 32'(k[1:0]));
        end
        apb(1'b0, burst_pkg::OFS_START, 32'h0);
        check(rd & 32'h3, 32'h0);
        cpu_port2_bit0 <= 1'b0;
        cpu_port2_bit1 <= 1'b0;
        $display("test cpu_both done");
    endtask : test_cpu_both

    // Mode 001: generator A on A, port bit 1 on B; a low enable freezes the burst
    task automatic test_gen_a_cpu_b;
        apb(1'b1, burst_pkg::OFS_MODE, 32'h1);
        apb(1'b1, burst_pkg::OFS_CFG_A, cfg(1, 8, 1));
        wait_clear(2);
        apb(1'b1, burst_pkg::OFS_START, 32'h3);
        apb(1'b0, burst_pkg::OFS_START, 32'h0);
        check(rd & 32'h3, 32'h1);
        clk_en <= 1'b0;
        cpu_port2_bit1 <= 1'b1;
        repeat (20) @(posedge pclk);
        #1;
        check({30'h0, gate_output_b, gate_output_a}, 32'h1);
        clk_en <= 1'b1;
        repeat (20) @(posedge pclk);
        #1;
        check({30'h0, gate_output_b, gate_output_a}, 32'h2);
        check({24'h0, pulses_a}, 32'd1);
        cpu_port2_bit1 <= 1'b0;
        $display("test gen_a_cpu_b done");
    endtask : test_gen_a_cpu_b

    // Push-pull pair from channel A timing with a dead gap; zero count ignored
    task automatic test_push_pull;
        apb(1'b1, burst_pkg::OFS_MODE, 32'h0);
        apb(1'b1, burst_pkg::OFS_GAP, 32'h1);
        apb(1'b1, burst_pkg::OFS_CFG_A, cfg(2, 1, 1));
        wait_clear(2);
        apb(1'b1, burst_pkg::OFS_START, 32'h1);
        repeat (30) @(posedge pclk);
        #1;
        check({24'h0, pulses_a}, 32'd2);
        check({24'h0, pulses_b}, 32'd2);
        check({31'h0, shoot_through}, 32'h0);
        apb(1'b1, burst_pkg::OFS_CFG_A, cfg(0, 1, 1));
        wait_clear(2);
        apb(1'b1, burst_pkg::OFS_START, 32'h1);
        repeat (20) @(posedge pclk);
        #1;
        check({24'h0, pulses_a}, 32'd0);
        $display("test push_pull done");
    endtask : test_push_pull

    task automatic summarize;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        test_reset_map();
        test_gen_both();
        test_cpu_a_gen_b();
        test_cpu_both();
        test_gen_a_cpu_b();
        test_push_pull();
        summarize();
    end

    // Whole run is about six hundred cycles; allow ample margin
    initial begin
        #100000;
        failures++;
        summarize();
    end
endmodule : tb_ultrasonic_burst_pulse_generator
`default_nettype wire
